/* logic/rfa_field.sv */
// one register field implementing a chosen access policy
// assumes rd_en and wr_en are single-cycle strobes, one per access
module rfa_field
	import rfa_pkg::*;
#(
	parameter rfa_policy_type POLICY = RFA_RW,
	parameter int             W      = RFA_FIELD_W,
	parameter logic [W-1:0]   RSTV   = '0
)(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// field access
	rfa_field_if.fld  f
);

	logic [W-1:0] val_r;
	logic [W-1:0] val_nxt;
	logic [W-1:0] trig_r;
	logic [W-1:0] trig_nxt;

	// next stored value per policy; hardware set wins over clears
	always_comb
	begin
		val_nxt  = val_r;
		trig_nxt = '0;
		unique case (POLICY)
			RFA_RW:  if (f.wr_en) val_nxt = f.wdata;
			RFA_RO:  val_nxt = f.hw_val;
			RFA_WO:  if (f.wr_en) val_nxt = f.wdata;
			RFA_W1C:
			begin
				if (f.wr_en) val_nxt = val_r & ~f.wdata;
				val_nxt = val_nxt | f.hw_set;
			end
			RFA_W0C:
			begin
				if (f.wr_en) val_nxt = val_r & f.wdata;
				val_nxt = val_nxt | f.hw_set;
			end
			RFA_RC:
			begin
				if (f.rd_en) val_nxt = RFA_ZERO[W-1:0];
				val_nxt = val_nxt | f.hw_set;
			end
			RFA_RS:  if (f.wr_en) val_nxt = val_r | f.wdata;
			RFA_WT:
			begin
				val_nxt = f.hw_val;
				if (f.wr_en) trig_nxt = '1;
			end
			RFA_TOG: if (f.wr_en) val_nxt = val_r ^ f.wdata;
			default: val_nxt = val_r;
		endcase
	end

	// state registers
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			val_r  <= RSTV;
			trig_r <= '0;
		end
		else
		begin
			val_r  <= val_nxt;
			trig_r <= trig_nxt;
		end
	end

	// read data: write-only reads back reset value
	assign f.rdata = (POLICY == RFA_WO) ? RSTV : val_r;
	assign f.value = val_r;
	assign f.trig  = trig_r;

	rc_once_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(POLICY == RFA_RC && f.rd_en && f.hw_set == '0)
		|=> val_r == '0)
		else $error("clear-on-read did not clear");
	tog_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(POLICY == RFA_TOG && f.wr_en)
		|=> val_r == ($past(val_r) ^ $past(f.wdata)))
		else $error("toggle result wrong");
	w1c_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(POLICY == RFA_W1C && f.wr_en && f.hw_set == '0)
		|=> val_r == ($past(val_r) & ~$past(f.wdata)))
		else $error("w1c result wrong");
	w0c_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(POLICY == RFA_W0C && f.wr_en && f.hw_set == '0)
		|=> val_r == ($past(val_r) & $past(f.wdata)))
		else $error("w0c result wrong");
	set_only_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(POLICY == RFA_RS) |=> (val_r & $past(val_r)) == $past(val_r))
		else $error("set-only bit cleared");
	wt_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(POLICY == RFA_WT && f.wr_en) |=> f.trig == '1)
		else $error("trigger missing");
	wo_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(POLICY == RFA_WO) |-> f.rdata == RSTV)
		else $error("write-only read leaked");
	rw_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(POLICY == RFA_RW && !f.wr_en) |=> $stable(val_r))
		else $error("rw changed without write");

endmodule : rfa_field

/* logic/rfa_pkg.sv */
// register field access policy constants and types
// assumes a single clock domain and a generic software register port
// What this block does
// - read/write field returns last software-written value; writes update it
// - read-only field returns hardware value and ignores software writes
// - write-only field accepts writes but reads return its reset value
// - clear-on-write-one field is readable; writing 1 clears, 0 no effect
// - clear-on-write-zero field is readable; writing 0 clears, 1 no effect
// - clear-on-read field returns value on read then clears; writes ignored
// - set-only field is readable; writing 1 sets, writing 0 no effect
// - write-trigger field readable; any write fires event, value unchanged
// - toggle field inverts on written 1; written 0 leaves it unchanged
// - read/write, set-only and toggle bits change only by software; hw_set also sets W1C, W0C and clear-on-read bits
package rfa_pkg;

	// access policies selectable per field
	typedef enum logic [3:0] {
		RFA_RW,
		RFA_RO,
		RFA_WO,
		RFA_W1C,
		RFA_W0C,
		RFA_RC,
		RFA_RS,
		RFA_WT,
		RFA_TOG
	} rfa_policy_type;

	localparam int RFA_FIELD_W = 8;
	localparam logic [RFA_FIELD_W-1:0] RFA_RST_VAL = 8'h00;
	localparam logic [RFA_FIELD_W-1:0] RFA_ZERO    = 8'h00;

endpackage : rfa_pkg

/* logic/rfa_field_if.sv */
// interface carrying one field's software access and hardware side
// assumes one clock; strobes are one-cycle pulses
interface rfa_field_if #(parameter int W = 8);
	logic         wr_en;
	logic         rd_en;
	logic [W-1:0] wdata;
	logic [W-1:0] hw_set;
	logic [W-1:0] hw_val;
	logic [W-1:0] rdata;
	logic [W-1:0] value;
	logic [W-1:0] trig;

	modport ctl (output wr_en, rd_en, wdata, hw_set, hw_val,
		input rdata, value, trig);
	modport fld (input wr_en, rd_en, wdata, hw_set, hw_val,
		output rdata, value, trig);
endinterface : rfa_field_if

/* logic/rfa_bank.sv */
// bank of nine fields, one per access policy, behind a field-select port
// assumes a generic single-cycle read/write port on the same clock
module rfa_bank
	import rfa_pkg::*;
#(
	parameter int W = RFA_FIELD_W
)(
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rstn,
	// software port
	input  wire logic [3:0]    sel,
	input  wire logic          wr_en,
	input  wire logic          rd_en,
	input  wire logic [W-1:0]  wdata,
	output logic      [W-1:0]  rdata_r,
	// hardware side
	input  wire logic [W-1:0]  hw_set,
	input  wire logic [W-1:0]  hw_val,
	output logic      [9*W-1:0] field_value,
	output logic               trig_pulse
);

	localparam int N = 9;
	logic [W-1:0] rd_mux [N];
	logic [N-1:0] trig_v;
	logic [W-1:0] rdata_nxt;

	// one field per policy, strobes routed only to the selected one
	for (genvar i = 0; i < N; i++)
	begin : g_fld
		rfa_field_if #(.W(W)) fi ();
		assign fi.wr_en  = wr_en && (sel == 4'(i));
		assign fi.rd_en  = rd_en && (sel == 4'(i));
		assign fi.wdata  = wdata;
		assign fi.hw_set = hw_set;
		assign fi.hw_val = hw_val;
		rfa_field #(
			.POLICY (rfa_policy_type'(i)),
			.W      (W),
			.RSTV   (RFA_RST_VAL[W-1:0])
		) u_fld (
			.ref_clk (ref_clk),
			.rstn    (rstn),
			.f       (fi)
		);
		assign rd_mux[i]                = fi.rdata;
		assign field_value[i*W +: W]    = fi.value;
		assign trig_v[i]                = fi.trig[0];
	end

	// read mux; unmapped selects read zero
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (rd_en)
			rdata_nxt = (sel < 4'(N)) ? rd_mux[sel] : RFA_ZERO[W-1:0];
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			rdata_r <= '0;
		else
			rdata_r <= rdata_nxt;
	end

	assign trig_pulse = |trig_v;

endmodule : rfa_bank

/* verif/rfa_bank_tb.sv */
// bench for the nine-field access policy bank
// assumes rfa_bank ports, one 100 MHz clock, sync active-low reset
`define CHK(n, e, a) begin check_count++; \
	if ((a) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module rfa_bank_tb
	import rfa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk;
	logic        rstn;
	logic [3:0]  sel;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  wdata;
	logic [7:0]  rdata_r;
	logic [7:0]  hw_set;
	logic [7:0]  hw_val;
	logic [71:0] field_value;
	logic        trig_pulse;
	int          num_errors = 0;
	int          check_count = 0;

	rfa_bank dut (.ref_clk(ref_clk), .rstn(rstn), .sel(sel), .wr_en(wr_en),
		.rd_en(rd_en), .wdata(wdata), .rdata_r(rdata_r), .hw_set(hw_set),
		.hw_val(hw_val), .field_value(field_value), .trig_pulse(trig_pulse));

	// verdict and end of run
	task automatic final_report();
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	// one write strobe, field settled on return
	task automatic wr(input logic [3:0] s, input logic [7:0] d);
		@(posedge ref_clk);
		sel <= s;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
		#1;
	endtask : wr

	// one read strobe, read data settled on return
	task automatic rd(input logic [3:0] s);
		@(posedge ref_clk);
		sel <= s;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
	endtask : rd

	// one-cycle hardware set pulse
	task automatic hs(input logic [7:0] v);
		@(posedge ref_clk);
		hw_set <= v;
		@(posedge ref_clk);
		hw_set <= 8'h00;
		#1;
	endtask : hs

	// plain field keeps writes, hardware set leaves it alone
	task automatic t_rw();
		wr(4'h0, 8'hA5);
		rd(4'h0);
		`CHK("rw", 8'hA5, rdata_r)
		hs(8'hFF);
		`CHK("rw_hw", 8'hA5, field_value[7:0])
	endtask : t_rw

	// read-only and write-only fields
	task automatic t_ro_wo();
		wr(4'h1, 8'hFF);
		rd(4'h1);
		`CHK("ro", 8'h3C, rdata_r)
		`CHK("ro_keep", 8'h3C, field_value[15:8])
		wr(4'h2, 8'h5A);
		`CHK("wo_keep", 8'h5A, field_value[23:16])
		rd(4'h2);
		`CHK("wo", RFA_RST_VAL, rdata_r)
	endtask : t_ro_wo

	// clear by written ones and by written zeros
	task automatic t_clr();
		wr(4'h3, 8'h0F);
		rd(4'h3);
		`CHK("w1c", 8'hF0, rdata_r)
		wr(4'h4, 8'h0F);
		wr(4'h4, 8'hFF);
		rd(4'h4);
		`CHK("w0c", 8'h0F, rdata_r)
	endtask : t_clr

	// clear on read, once per access, writes ignored
	task automatic t_rc();
		wr(4'h5, 8'h00);
		rd(4'h5);
		`CHK("rc1", 8'hFF, rdata_r)
		rd(4'h5);
		`CHK("rc2", 8'h00, rdata_r)
	endtask : t_rc

	// set-only accumulates ones
	task automatic t_rs();
		wr(4'h6, 8'h11);
		wr(4'h6, 8'h00);
		wr(4'h6, 8'h22);
		rd(4'h6);
		`CHK("rs", 8'h33, rdata_r)
	endtask : t_rs

	// trigger fires once, stored value kept
	task automatic t_wt();
		wr(4'h7, 8'hFF);
		`CHK("trig", 1'b1, trig_pulse)
		@(posedge ref_clk);
		#1;
		`CHK("trig_end", 1'b0, trig_pulse)
		`CHK("wt", 8'h3C, field_value[63:56])
	endtask : t_wt

	// toggle on ones, then an unmapped select
	task automatic t_tog();
		wr(4'h8, 8'h0F);
		wr(4'h8, 8'h03);
		wr(4'h8, 8'h00);
		rd(4'h8);
		`CHK("tog", 8'h0C, rdata_r)
		rd(4'h9);
		`CHK("unmapped", 8'h00, rdata_r)
	endtask : t_tog

	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// watchdog
	initial
	begin
		#50000;
		num_errors++;
		final_report();
	end

	// reset then scenarios
	initial
	begin
		rstn = 1'b0;
		sel = 4'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wdata = 8'h00;
		hw_set = 8'h00;
		hw_val = 8'h3C;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		t_rw();
		t_ro_wo();
		t_clr();
		t_rc();
		t_rs();
		t_wt();
		t_tog();
		final_report();
	end
endmodule : rfa_bank_tb
